// File: inc/art_defines.svh
// Constants of the autoreload PWM timer: register indexes, fields, resets, timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef ART_DEFINES_SVH
`define ART_DEFINES_SVH

// Register indexes; the AXI byte address is four times the index.
`define ART_IDX_CSR 5'h0d
`define ART_IDX_CNTH 5'h0e
`define ART_IDX_CNTL 5'h0f
`define ART_IDX_RLDH 5'h10
`define ART_IDX_RLDL 5'h11
`define ART_IDX_OUTEN 5'h12
`define ART_IDX_PWMCS 5'h13
`define ART_IDX_DUTH 5'h17
`define ART_IDX_DUTL 5'h18

// Field positions of timer_control_status.
`define ART_CSR_CKSEL_HI 4
`define ART_CSR_CKSEL_LO 3
`define ART_CSR_WRAP 2
`define ART_CSR_WRAPIE 1
`define ART_CSR_MATCHIE 0
// Field positions of pwm_channel_status and the output-enable register.
`define ART_PCS_INVERT 1
`define ART_PCS_MATCH 0
`define ART_OE_BIT 0

// Reset values.
`define ART_RST_BYTE 8'h00
`define ART_RST_WORD 12'h000
`define ART_RST_CKSEL 2'b00

// Counter span and slow-mode prescale.
`define ART_COUNT_MAX 12'hfff
`define ART_SLOW_DIV 32
`define ART_SLOW_LAST 5'h1f

// AXI responses.
`define ART_RESP_OKAY 2'b00
`define ART_RESP_SLVERR 2'b10

`endif

// File: inc/art_pkg.sv
// Types of the autoreload PWM timer.
// Assumes art_defines.svh is compiled alongside for the numeric constants.
`default_nettype none

package art_pkg;

    typedef enum logic [1:0]
    {
        CLK_OFF = 2'b00,
        CLK_LITE = 2'b01,
        CLK_CPU = 2'b10,
        CLK_RSVD = 2'b11
    } art_clksel_type;

    typedef enum logic [0:0]
    {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } art_wstate_type;

    typedef enum logic [0:0]
    {
        RD_IDLE = 1'b0,
        RD_DATA = 1'b1
    } art_rstate_type;

endpackage

`default_nettype wire

// File: verilog/art_tick_gen.sv
// Counter clock enable: selects the source, applies slow-mode division and stops.
// Assumes liteTick is a one-cycle pulse from logic on the same clock.
`include "art_defines.svh"
`default_nettype none

module art_tick_gen
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] clockSelect,
    input wire logic liteTick,
    input wire logic slowMode,
    input wire logic haltMode,
    input wire logic activeHaltMode,
    input wire logic wrapIrqEn,
    output logic counterTick
);

    logic sourceEvent;
    logic running;
    logic [4:0] prescale;

    ////////////////////////////////////////////////////////////////////////////////
    // Source selection and low-power gating.

    always_comb
    begin
        case (art_pkg::art_clksel_type'(clockSelect))
            art_pkg::CLK_LITE: sourceEvent = liteTick;
            art_pkg::CLK_CPU: sourceEvent = 1'b1;
            default: sourceEvent = 1'b0;
        endcase
    end

    // Halt stops all; active-halt keeps only the lite tick with wrap interrupt on.
    assign running = !haltMode && (!activeHaltMode ||
        (clockSelect == art_pkg::CLK_LITE && wrapIrqEn)); // R2

    ////////////////////////////////////////////////////////////////////////////////
    // Slow mode passes one source event in every thirty-two.

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prescale <= 5'h00;
        end
        else if (sourceEvent && running && slowMode)
        begin
            prescale <= prescale + 5'h01; // R1
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            counterTick <= 1'b0;
        end
        else
        begin
            counterTick <= sourceEvent && running &&
                (!slowMode || prescale == `ART_SLOW_LAST); // R1
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    halt_stop_a: assert property (haltMode |=> !counterTick) // R2
        else $error("Counter ticked during halt.");

    slow_gap_a: assert property ((counterTick && slowMode && $past(slowMode)) |-> // R1
        $past(prescale) == `ART_SLOW_LAST)
        else $error("Slow mode tick not on prescale wrap.");

endmodule

`default_nettype wire

// File: verilog/art_timer.sv
// Notes on behaviour
// R1 - Slow mode divides the counter's input clock by 32; wait changes nothing.
// R2 - Halt stops the counter; active-halt too unless lite tick and wrap irq.
// R3 - Wrap wakes wait, and active-halt with lite tick; match wakes wait only.
// R4 - Each irq needs its flag, its enable and a clear CPU mask.
// R5 - Clock select: 00 off, 01 lite tick, 10 CPU clock, 11 reserved; resets 00.
// R6 - Wrap flag sets on FFF to reload; reading control/status clears it.
// R7 - After the read, wrap flag lingers one more counter clock.
// R8 - 12-bit counter resets to zero, counts each selected tick, read as bytes.
// R9 - Software reads low byte then high byte and allows for a carry.
// R10 - On overflow the counter restarts from the reload value.
// R11 - Reload value sets the PWM period, from reload up to FFF.
// R12 - Software writes the duty high byte before the low byte.
// R13 - Output enabled: duty sets PWM; disabled: duty is the compare value.
// R14 - Invert bit, reset 0, inverts the PWM output when 1.
// R15 - Match flag sets on counter equal compare; reading channel status clears.
// R16 - Software keeps reserved bits written as zero.
// R17 - Overflow loads the duty shadow and drives high; match drives low.
// R18 - Compare value acts at once; high write suspends compare until low write.
// R19 - Output compare is idle while the compare value is zero.
// R20 - Interrupt outputs are levels held while flag and enable stay set.
// Top of the 12-bit autoreload PWM timer with an AXI4-Lite register slave.
// Assumes one clock, a synchronous reset and same-clock mode and tick inputs.
`include "art_defines.svh"
`default_nettype none

module art_timer
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic liteTick,
    input wire logic slowMode,
    input wire logic waitMode,
    input wire logic activeHaltMode,
    input wire logic haltMode,
    input wire logic cpuIrqMask,
    output logic pwmOutput,
    output logic pwmOutputEn,
    output logic wrapIrq,
    output logic matchIrq,
    output logic wakeRequest
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    function automatic logic isMapped(input logic [7:0] addr);
        logic [4:0] idx;
        idx = addr[6:2];
        isMapped = addr[7] == 1'b0 && addr[1:0] == 2'b00 &&
            ((idx >= `ART_IDX_CSR && idx <= `ART_IDX_PWMCS) ||
            idx == `ART_IDX_DUTH || idx == `ART_IDX_DUTL);
    endfunction

    function automatic logic hitIndex(input logic [7:0] addr, input logic [4:0] idx);
        hitIndex = isMapped(addr) && addr[6:2] == idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    logic [1:0] counterClockSelect;
    logic wrapIrqEn;
    logic matchIrqEn;
    logic wrapFlag;
    logic wrapClearPending;
    logic matchFlag;
    logic pwmOutEn;
    logic pwmInvert;
    logic [11:0] countValue;
    logic [11:0] reloadValue;
    logic [11:0] dutyValue;
    logic [11:0] dutyShadow;
    logic highPending;
    logic pwmLevel;
    logic counterTick;
    logic [11:0] next_count;
    logic atMax;
    logic [11:0] compareValue;
    logic compareEnabled;
    logic matchHit;

    art_pkg::art_wstate_type wrState;
    art_pkg::art_rstate_type rdState;
    logic awHeld;
    logic wHeld;
    logic [7:0] wrAddr;
    logic [7:0] wrByte;
    logic wrByteEn;
    logic doWrite;
    logic doRead;
    logic readClearsWrap;
    logic readClearsMatch;
    logic [7:0] readByte;

    ////////////////////////////////////////////////////////////////////////////////
    // Counter clock.

    art_tick_gen tickGen
    (
        .clk(clk),
        .reset(reset),
        .clockSelect(counterClockSelect),
        .liteTick(liteTick),
        .slowMode(slowMode),
        .haltMode(haltMode),
        .activeHaltMode(activeHaltMode),
        .wrapIrqEn(wrapIrqEn),
        .counterTick(counterTick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Counter and compare.

    assign atMax = countValue == `ART_COUNT_MAX;
    assign next_count = atMax ? reloadValue : countValue + 12'h001; // R10 R11

    // PWM compares with the shadow, output compare with the live value.
    assign compareValue = pwmOutEn ? dutyShadow : dutyValue; // R13 R17
    assign compareEnabled = !highPending && (pwmOutEn || dutyValue != 12'h000); // R18 R19
    assign matchHit = counterTick && compareEnabled && next_count == compareValue; // R15

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            countValue <= `ART_RST_WORD;
        end
        else if (counterTick)
        begin
            countValue <= next_count; // R8 R10
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dutyShadow <= `ART_RST_WORD;
        end
        else if (counterTick && atMax)
        begin
            dutyShadow <= dutyValue; // R17
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pwmLevel <= 1'b0;
        end
        else if (counterTick && atMax)
        begin
            pwmLevel <= 1'b1; // R17
        end
        else if (matchHit && pwmOutEn)
        begin
            pwmLevel <= 1'b0; // R17
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags; a new event beats a clear in the same cycle.

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wrapClearPending <= 1'b0;
        end
        else if (counterTick)
        begin
            wrapClearPending <= 1'b0;
        end
        else if (readClearsWrap && wrapFlag)
        begin
            wrapClearPending <= 1'b1; // R7
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wrapFlag <= 1'b0;
        end
        else if (counterTick && atMax)
        begin
            wrapFlag <= 1'b1; // R6
        end
        else if (counterTick && (wrapClearPending || readClearsWrap))
        begin
            wrapFlag <= 1'b0; // R6 R7
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            matchFlag <= 1'b0;
        end
        else if (matchHit)
        begin
            matchFlag <= 1'b1; // R15
        end
        else if (readClearsMatch)
        begin
            matchFlag <= 1'b0; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wrapIrq <= 1'b0;
            matchIrq <= 1'b0;
            wakeRequest <= 1'b0;
            pwmOutput <= 1'b0;
            pwmOutputEn <= 1'b0;
        end
        else
        begin
            wrapIrq <= wrapFlag && wrapIrqEn && !cpuIrqMask; // R4 R20
            matchIrq <= matchFlag && matchIrqEn && !cpuIrqMask; // R4 R20
            wakeRequest <= (waitMode && !haltMode &&
                ((wrapFlag && wrapIrqEn) || (matchFlag && matchIrqEn))) ||
                (activeHaltMode && !haltMode && wrapFlag && wrapIrqEn &&
                counterClockSelect == art_pkg::CLK_LITE); // R3
            pwmOutput <= pwmOutEn && (pwmLevel ^ pwmInvert); // R13 R14
            pwmOutputEn <= pwmOutEn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Software registers.

    assign doWrite = wrState == art_pkg::WR_IDLE && awHeld && wHeld;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            counterClockSelect <= `ART_RST_CKSEL;
            wrapIrqEn <= 1'b0;
            matchIrqEn <= 1'b0;
            pwmOutEn <= 1'b0;
            pwmInvert <= 1'b0;
        end
        else if (doWrite && wrByteEn)
        begin
            if (hitIndex(wrAddr, `ART_IDX_CSR))
            begin
                counterClockSelect <= wrByte[`ART_CSR_CKSEL_HI:`ART_CSR_CKSEL_LO]; // R5
                wrapIrqEn <= wrByte[`ART_CSR_WRAPIE];
                matchIrqEn <= wrByte[`ART_CSR_MATCHIE];
            end
            if (hitIndex(wrAddr, `ART_IDX_OUTEN))
            begin
                pwmOutEn <= wrByte[`ART_OE_BIT]; // R13
            end
            if (hitIndex(wrAddr, `ART_IDX_PWMCS))
            begin
                pwmInvert <= wrByte[`ART_PCS_INVERT]; // R14
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reloadValue <= `ART_RST_WORD;
            dutyValue <= `ART_RST_WORD;
            highPending <= 1'b0;
        end
        else if (doWrite && wrByteEn)
        begin
            if (hitIndex(wrAddr, `ART_IDX_RLDH))
            begin
                reloadValue[11:8] <= wrByte[3:0];
            end
            if (hitIndex(wrAddr, `ART_IDX_RLDL))
            begin
                reloadValue[7:0] <= wrByte;
            end
            if (hitIndex(wrAddr, `ART_IDX_DUTH))
            begin
                dutyValue[11:8] <= wrByte[3:0];
                highPending <= 1'b1; // R18
            end
            if (hitIndex(wrAddr, `ART_IDX_DUTL))
            begin
                dutyValue[7:0] <= wrByte;
                highPending <= 1'b0; // R18
            end
        end
    end

    always_comb
    begin
        readByte = 8'h00;
        if (hitIndex(s_axi_araddr, `ART_IDX_CSR))
        begin
            readByte = {3'h0, counterClockSelect, wrapFlag, wrapIrqEn, matchIrqEn};
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_CNTH))
        begin
            readByte = {4'h0, countValue[11:8]}; // R8
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_CNTL))
        begin
            readByte = countValue[7:0]; // R8
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_RLDH))
        begin
            readByte = {4'h0, reloadValue[11:8]};
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_RLDL))
        begin
            readByte = reloadValue[7:0];
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_OUTEN))
        begin
            readByte = {7'h00, pwmOutEn};
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_PWMCS))
        begin
            readByte = {6'h00, pwmInvert, matchFlag};
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_DUTH))
        begin
            readByte = {4'h0, dutyValue[11:8]};
        end
        else if (hitIndex(s_axi_araddr, `ART_IDX_DUTL))
        begin
            readByte = dutyValue[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wrState <= art_pkg::WR_IDLE;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            wrAddr <= 8'h00;
            wrByte <= 8'h00;
            wrByteEn <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ART_RESP_OKAY;
        end
        else
        begin
            case (wrState)
                art_pkg::WR_IDLE:
                begin
                    s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
                    s_axi_wready <= !wHeld && !(s_axi_wvalid && s_axi_wready);
                    if (s_axi_awvalid && s_axi_awready)
                    begin
                        awHeld <= 1'b1;
                        wrAddr <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready)
                    begin
                        wHeld <= 1'b1;
                        wrByte <= s_axi_wdata[7:0];
                        wrByteEn <= s_axi_wstrb[0];
                    end
                    if (doWrite)
                    begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= isMapped(wrAddr) ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
                        wrState <= art_pkg::WR_RESP;
                    end
                end
                art_pkg::WR_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        awHeld <= 1'b0;
                        wHeld <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wrState <= art_pkg::WR_IDLE;
                    end
                end
                default:
                begin
                    wrState <= art_pkg::WR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel; reading a status register clears its flag.

    assign doRead = s_axi_arvalid && s_axi_arready;
    assign readClearsWrap = doRead && hitIndex(s_axi_araddr, `ART_IDX_CSR); // R6
    assign readClearsMatch = doRead && hitIndex(s_axi_araddr, `ART_IDX_PWMCS); // R15

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdState <= art_pkg::RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ART_RESP_OKAY;
        end
        else
        begin
            case (rdState)
                art_pkg::RD_IDLE:
                begin
                    s_axi_arready <= !doRead;
                    if (doRead)
                    begin
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= {24'h000000, readByte};
                        s_axi_rresp <= isMapped(s_axi_araddr) ?
                            `ART_RESP_OKAY : `ART_RESP_SLVERR;
                        rdState <= art_pkg::RD_DATA;
                    end
                end
                art_pkg::RD_DATA:
                begin
                    if (s_axi_rready)
                    begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rdState <= art_pkg::RD_IDLE;
                    end
                end
                default:
                begin
                    rdState <= art_pkg::RD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence wrapTick;
        counterTick && atMax;
    endsequence

    sequence pwmHighSeen;
        pwmLevel ##1 (!$past(pwmOutEn) || pwmOutput == !$past(pwmInvert));
    endsequence

    wrap_reload_a: assert property (wrapTick |=> // R10
        countValue == $past(reloadValue) && wrapFlag)
        else $error("Counter did not reload on wrap.");

    count_step_a: assert property ((counterTick && !atMax) |=> // R8
        countValue == $past(countValue) + 12'h001)
        else $error("Counter did not advance on tick.");

    count_hold_a: assert property (!counterTick |=> $stable(countValue)) // R8
        else $error("Counter moved without a tick.");

    wrap_linger_a: assert property ((readClearsWrap && wrapFlag && !counterTick) |=> // R7
        wrapFlag)
        else $error("Wrap flag dropped before a counter tick.");

    wrap_irq_a: assert property ((wrapFlag && wrapIrqEn && !cpuIrqMask) |=> wrapIrq) // R4
        else $error("Wrap interrupt not raised.");

    match_irq_a: assert property (!matchFlag |=> !matchIrq) // R20
        else $error("Match interrupt without flag.");

    match_set_a: assert property (matchHit |=> matchFlag) // R15
        else $error("Match flag not set on compare.");

    compare_suspend_a: assert property ((highPending && !matchFlag) |=> !matchFlag) // R18
        else $error("Compare active between duty byte writes.");

    pwm_start_a: assert property (wrapTick |=> // R17
        pwmHighSeen)
        else $error("PWM output not set on wrap.");

endmodule

`default_nettype wire

// File: verification/art_pwm_load.sv
// Load on the PWM pin: measures the length of each high and low run.
// Assumes the pin and its enable are registers on the same clock.
`default_nettype none

module art_pwm_load
(
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    input wire logic pinEn,
    output logic [7:0] highLen,
    output logic [7:0] lowLen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last;
    logic [7:0] run;

    ////////////////////////////////////////////////////////////////////////////////
    // A run closes when the pin changes; a released pin restarts the count.
    always_ff @(posedge clk)
    begin
        if (reset || !pinEn)
        begin
            run <= 8'h01;
            last <= pin;
            highLen <= 8'h00;
            lowLen <= 8'h00;
        end
        else if (pin != last)
        begin
            if (last) highLen <= run;
            else lowLen <= run;
            run <= 8'h01;
            last <= pin;
        end
        else run <= run + 8'h01;
    end
endmodule

`default_nettype wire

// File: verification/art_timer_tb.sv
// Self-checking bench of the autoreload PWM timer.
// Assumes the timer and the load model are compiled before it.
`default_nettype none

module art_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, highLen, lowLen, rd8;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr;
    logic waitMode = 1'b0, cpuIrqMask = 1'b0, zero = 1'b0, haltMode = 1'b0;
    logic pwmOutput, pwmOutputEn, wrapIrq, matchIrq, wakeRequest;
    int fail_count = 0, n_tests = 0;

    always #25 clk = ~clk;

    art_timer art_timer_i (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .liteTick(zero), .slowMode(zero), .waitMode(waitMode),
        .activeHaltMode(zero), .haltMode(haltMode), .cpuIrqMask(cpuIrqMask),
        .pwmOutput(pwmOutput), .pwmOutputEn(pwmOutputEn), .wrapIrq(wrapIrq),
        .matchIrq(matchIrq), .wakeRequest(wakeRequest));

    art_pwm_load art_pwm_load_i (.clk(clk), .reset(reset), .pin(pwmOutput),
        .pinEn(pwmOutputEn), .highLen(highLen), .lowLen(lowLen));

    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task hung;
        $display("CHECK FAILED bus wait expected answer seen none");
        fail_count++;
        test_done();
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 100) hung();
    endtask

    task rd(input logic [7:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd8 = rdata[7:0];
        rr = rresp;
        rready <= 1'b0;
        if (n == 100) hung();
    endtask

    task rc(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(what, exp, rd8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rc(8'h34, 8'h00, "control");
        rc(8'h3c, 8'h00, "count low");
        rc(8'h4c, 8'h00, "channel status");
        rd(8'h00);
        chk("unmapped resp", 8'h02, {6'h0, rr});
        $display("test reset done");
    endtask

    task t_wrap;
        int n;
        wr(8'h40, 8'h0f);
        wr(8'h44, 8'hf0);
        wr(8'h34, 8'h12);
        for (n = 0; n < 5000 && wrapIrq !== 1'b1; n++) @(posedge clk);
        if (n == 5000) hung();
        chk("wrap irq", 8'h01, {7'h0, wrapIrq});
        rc(8'h38, 8'h0f, "count high");
        waitMode <= 1'b1;
        repeat (3) @(posedge clk);
        chk("wake", 8'h01, {7'h0, wakeRequest});
        cpuIrqMask <= 1'b1;
        waitMode <= 1'b0;
        repeat (3) @(posedge clk);
        chk("masked irq", 8'h00, {7'h0, wrapIrq});
        cpuIrqMask <= 1'b0;
        wr(8'h34, 8'h02);
        rc(8'h34, 8'h06, "wrap flag");
        rc(8'h34, 8'h06, "flag lingers");
        $display("test wrap done");
    endtask

    task t_pwm;
        wr(8'h5c, 8'h0f);
        wr(8'h60, 8'hf4);
        wr(8'h48, 8'h01);
        wr(8'h34, 8'h10);
        repeat (60) @(posedge clk);
        chk("pin enable", 8'h01, {7'h0, pwmOutputEn});
        chk("high run", 8'h04, highLen);
        chk("low run", 8'h0c, lowLen);
        wr(8'h4c, 8'h02);
        repeat (40) @(posedge clk);
        chk("inverted high", 8'h0c, highLen);
        wr(8'h48, 8'h00);
        repeat (40) @(posedge clk);
        chk("pin off", 8'h00, {7'h0, pwmOutput});
        wr(8'h34, 8'h11);
        repeat (3) @(posedge clk);
        chk("match irq", 8'h01, {7'h0, matchIrq});
        rc(8'h4c, 8'h03, "match flag");
        $display("test pwm done");
    endtask

    task t_modes;
        haltMode <= 1'b1;
        rd(8'h3c);
        rc(8'h3c, rd8, "halted count");
        haltMode <= 1'b0;
        rc(8'h38, 8'h0f, "count high");
        $display("test modes done");
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_wrap();
        t_pwm();
        t_modes();
        test_done();
    end
endmodule

`default_nettype wire
